// ---- core/ocp_osc_control.sv ----
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`default_nettype none

module ocp_osc_control #(
    parameter int HS_STABLE = ocp_pkg::HS_STABLE_CYCLES,
    parameter int XT_STABLE_SLOW = ocp_pkg::CRYSTAL_STABLE_SLOW_CYCLES,
    parameter int XT_STABLE_FAST = ocp_pkg::CRYSTAL_STABLE_FAST_CYCLES
) (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // AHB-Lite slave.
    input wire logic i_hsel,
    input wire logic [7:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // CPU and watchdog events.
    input wire logic i_halt_req,
    input wire logic i_wake,
    input wire logic i_clr_wdt,
    input wire logic i_wdt_timeout,
    // Oscillator and clock tree controls.
    output logic o_hs_osc_run,
    output logic o_crystal_run,
    output logic o_crystal_speedup,
    output logic [4:0] o_hs_freq_mhz,
    output logic o_hs_clk_on,
    output logic o_ls_clk_on,
    output logic o_sys_ls_sel,
    output logic o_sys_ls_crystal,
    output logic [2:0] o_sys_div_sel,
    output logic o_cpu_hold,
    output logic o_wdt_clear,
    output ocp_pkg::ocp_mode_t o_mode
);

    // ==========================================================
    // Bus decode.
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [7:0] sysclk_ctrl_reg;
    logic [1:0] hs_freq_reg;
    logic hs_en_reg;
    logic hs_stable_reg;
    logic [ocp_pkg::STABLE_CNT_W-1:0] hs_cnt_reg;
    logic xt_speedup_reg;
    logic xt_en_reg;
    logic xt_stable_reg;
    logic [ocp_pkg::STABLE_CNT_W-1:0] xt_cnt_reg;
    logic pdf_reg;
    logic to_reg;
    ocp_pkg::ocp_mode_t mode_reg;
    ocp_pkg::ocp_mode_t mode_next;

    // Registers take their write data in the data phase after the address.
    wire addr_ok = i_hsel & i_htrans[1] & i_hready;
    wire wr_start = addr_ok & i_hwrite;
    wire rd_start = addr_ok & ~i_hwrite;
    wire wr_sys = wr_pend_reg & (wr_addr_reg == ocp_pkg::SYSCLK_CTRL_ADDR);
    wire wr_hs = wr_pend_reg & (wr_addr_reg == ocp_pkg::HS_OSC_CTRL_ADDR);
    wire wr_xt = wr_pend_reg & (wr_addr_reg == ocp_pkg::CRYSTAL_OSC_CTRL_ADDR);
    wire [7:0] wdat = i_hwdata[7:0];

    // Field views of the system clock control register.
    wire [2:0] sysclk_sel = sysclk_ctrl_reg[ocp_pkg::SYSCLK_SEL_LSB +: 3];
    wire low_clk_src_sel = sysclk_ctrl_reg[ocp_pkg::LOW_CLK_SRC_SEL_BIT];
    wire hs_on_in_halt = sysclk_ctrl_reg[ocp_pkg::HS_ON_IN_HALT_BIT];
    wire ls_on_in_halt = sysclk_ctrl_reg[ocp_pkg::LS_ON_IN_HALT_BIT];
    wire halted = (mode_reg != ocp_pkg::MODE_FAST) && (mode_reg != ocp_pkg::MODE_SLOW);
    wire halt_go = i_halt_req & ~halted;

    // ==========================================================
    // Read multiplexer; sampled in the address phase so the data phase needs no wait.
    wire [7:0] rd_sys = {sysclk_sel, 2'h0, sysclk_ctrl_reg[2:0]};
    wire [7:0] rd_hs = {4'h0, hs_freq_reg, hs_stable_reg, hs_en_reg};
    wire [7:0] rd_xt = {5'h00, xt_speedup_reg, xt_stable_reg, xt_en_reg};
    wire [7:0] rd_st = {1'b0, 3'(mode_reg), 2'h0, to_reg, pdf_reg};
    wire [7:0] rd_mux = (i_haddr == ocp_pkg::SYSCLK_CTRL_ADDR) ? rd_sys :
                        (i_haddr == ocp_pkg::HS_OSC_CTRL_ADDR) ? rd_hs :
                        (i_haddr == ocp_pkg::CRYSTAL_OSC_CTRL_ADDR) ? rd_xt :
                        (i_haddr == ocp_pkg::STATUS_ADDR) ? rd_st : 8'h00;

    // Bus response registers; every transfer is zero-wait and OKAY.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            wr_pend_reg <= wr_start;
            wr_addr_reg <= i_haddr;
            o_hrdata <= rd_start ? {24'h000000, rd_mux} : 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // ==========================================================
    // Software controls.
    // A rewrite of the same code with the RC already running keeps the flag up.
    // Restarting then would stall the system clock for no gain.
    wire hs_restart = wr_hs & wdat[ocp_pkg::OSC_EN_BIT] &
                      (~hs_en_reg | (wdat[ocp_pkg::HS_RC_FREQ_SEL_LSB +: 2] != hs_freq_reg));
    wire xt_restart = wr_xt & wdat[ocp_pkg::OSC_EN_BIT] & ~xt_en_reg;
    // The crystal counts as the system clock whenever select is 111 with the crystal picked, stable or not.
    wire xt_is_sys = (sysclk_sel == ocp_pkg::SYSCLK_SEL_LOW) & low_clk_src_sel;
    wire speedup_wr = wr_xt & ~xt_is_sys;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sysclk_ctrl_reg <= ocp_pkg::SYSCLK_CTRL_RESET;
            hs_freq_reg <= ocp_pkg::HS_RC_FREQ_RESET;
            hs_en_reg <= ocp_pkg::HS_OSC_EN_RESET;
            xt_speedup_reg <= 1'b0;
            xt_en_reg <= 1'b0;
        end else begin
            if (wr_sys) begin
                sysclk_ctrl_reg <= {wdat[7:5], 2'h0, wdat[2:0]};
            end
            if (wr_hs) begin
                hs_freq_reg <= wdat[ocp_pkg::HS_RC_FREQ_SEL_LSB +: 2];
                hs_en_reg <= wdat[ocp_pkg::OSC_EN_BIT];
            end
            if (wr_xt) begin
                xt_en_reg <= wdat[ocp_pkg::OSC_EN_BIT];
            end
            if (speedup_wr) begin
                xt_speedup_reg <= wdat[ocp_pkg::CRYSTAL_SPEEDUP_BIT];
            end
        end
    end

    // ==========================================================
    // Oscillator run conditions; a halted mode stops the RC, and the crystal only when it is the low-speed source, unless its halt enable keeps it.
    wire hs_run = hs_en_reg & ~(halted & ~hs_on_in_halt);
    wire xt_run = xt_en_reg & ~(halted & ~ls_on_in_halt & low_clk_src_sel);
    wire [ocp_pkg::STABLE_CNT_W-1:0] hs_lim = ocp_pkg::STABLE_CNT_W'(HS_STABLE);
    wire [ocp_pkg::STABLE_CNT_W-1:0] xt_lim = xt_speedup_reg ?
        ocp_pkg::STABLE_CNT_W'(XT_STABLE_FAST) : ocp_pkg::STABLE_CNT_W'(XT_STABLE_SLOW);

    // Stable counters; a stopped oscillator must count again from zero when it restarts.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hs_cnt_reg <= '0;
            hs_stable_reg <= 1'b0;
            xt_cnt_reg <= '0;
            xt_stable_reg <= 1'b0;
        end else begin
            if (!hs_run || hs_restart) begin
                hs_cnt_reg <= '0;
                hs_stable_reg <= 1'b0;
            end else if (hs_cnt_reg != hs_lim) begin
                hs_cnt_reg <= hs_cnt_reg + 1'b1;
            end else begin
                hs_stable_reg <= 1'b1;
            end
            if (!xt_run || xt_restart) begin
                xt_cnt_reg <= '0;
                xt_stable_reg <= 1'b0;
            end else if (xt_cnt_reg < xt_lim) begin
                xt_cnt_reg <= xt_cnt_reg + 1'b1;
            end else begin
                xt_stable_reg <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Clock selection; the delivered choice only moves to a stable target.
    wire ls_target_ok = low_clk_src_sel ? xt_stable_reg : 1'b1;
    wire to_slow = (sysclk_sel == ocp_pkg::SYSCLK_SEL_LOW);
    wire sel_ok = to_slow ? ls_target_ok : hs_stable_reg;
    wire [4:0] freq_dec = (hs_freq_reg == 2'h1) ? ocp_pkg::FREQ_12_MHZ :
                          (hs_freq_reg == 2'h2) ? ocp_pkg::FREQ_16_MHZ :
                          ocp_pkg::FREQ_8_MHZ;

    // Holding the old source until the new one is stable keeps the mux glitch-free.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sys_ls_sel <= 1'b0;
            o_sys_ls_crystal <= 1'b0;
            o_sys_div_sel <= 3'h0;
            o_hs_freq_mhz <= ocp_pkg::FREQ_8_MHZ;
        end else begin
            if (sel_ok && !halted) begin
                o_sys_ls_sel <= to_slow;
                o_sys_ls_crystal <= low_clk_src_sel;
                o_sys_div_sel <= to_slow ? o_sys_div_sel : sysclk_sel;
            end
            if (hs_stable_reg) begin
                o_hs_freq_mhz <= freq_dec;
            end
        end
    end

    // ==========================================================
    // Mode sequencing; the halt enables pick the low-power mode.
    always_comb begin
        mode_next = mode_reg;
        if (halt_go) begin
            case ({hs_on_in_halt, ls_on_in_halt})
                2'b00: mode_next = ocp_pkg::MODE_SLEEP;
                2'b01: mode_next = ocp_pkg::MODE_IDLE_LS_ONLY;
                2'b11: mode_next = ocp_pkg::MODE_IDLE_BOTH_CLOCKS;
                default: mode_next = ocp_pkg::MODE_IDLE_HS_ONLY;
            endcase
        end else if (halted) begin
            mode_next = i_wake ? ocp_pkg::MODE_FAST : mode_reg;
        end else begin
            mode_next = o_sys_ls_sel ? ocp_pkg::MODE_SLOW : ocp_pkg::MODE_FAST;
        end
    end

    // Status flags; a time-out in the clearing cycle still wins.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_reg <= ocp_pkg::MODE_FAST;
            pdf_reg <= 1'b0;
            to_reg <= 1'b0;
            o_wdt_clear <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            pdf_reg <= halt_go | (pdf_reg & ~i_clr_wdt);
            to_reg <= i_wdt_timeout | (to_reg & ~halt_go);
            o_wdt_clear <= halt_go;
        end
    end

    // ==========================================================
    // Registered outputs to the oscillators and clock tree.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_hs_osc_run <= 1'b0;
            o_crystal_run <= 1'b0;
            o_crystal_speedup <= 1'b0;
            o_hs_clk_on <= 1'b0;
            o_ls_clk_on <= 1'b0;
            o_cpu_hold <= 1'b0;
            o_mode <= ocp_pkg::MODE_FAST;
        end else begin
            o_hs_osc_run <= hs_run;
            o_crystal_run <= xt_run;
            o_crystal_speedup <= xt_speedup_reg;
            o_hs_clk_on <= hs_run & hs_stable_reg;
            o_ls_clk_on <= ~(halted & ~ls_on_in_halt) & ls_target_ok;
            o_cpu_hold <= halted;
            o_mode <= mode_reg;
        end
    end

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    halt_flags_a: assert property (halt_go && !i_wdt_timeout |=> pdf_reg && !to_reg)
        else $error("halt entry did not set power-down and clear time-out");
    wdt_clear_a: assert property (halt_go |=> o_wdt_clear ##1 !o_wdt_clear)
        else $error("watchdog clear pulse missing on halt entry");
    freq_hold_a: assert property (!hs_stable_reg |=> $stable(o_hs_freq_mhz))
        else $error("delivered frequency moved while unstable");
    hs_restart_a: assert property (hs_restart |=> !hs_stable_reg ##1 !hs_stable_reg)
        else $error("high-speed stable flag did not clear on enable");
    speedup_lock_a: assert property (wr_xt && xt_is_sys |=> $stable(xt_speedup_reg))
        else $error("speed-up changed while crystal clocks the system");
    slow_wait_a: assert property ($rose(o_sys_ls_sel) && o_sys_ls_crystal
        |-> $past(xt_stable_reg))
        else $error("slow switch before crystal stable");
    fast_wait_a: assert property ($fell(o_sys_ls_sel) |-> $past(hs_stable_reg))
        else $error("fast resumed before high-speed stable");
    sleep_clock_a: assert property (halt_go && !hs_on_in_halt && !ls_on_in_halt
        |=> ##1 !o_hs_clk_on && (!o_ls_clk_on || !low_clk_src_sel))
        else $error("clocks still on in sleep");
    idle_ls_a: assert property (halt_go && !hs_on_in_halt && ls_on_in_halt
        |=> mode_reg == ocp_pkg::MODE_IDLE_LS_ONLY ##1 !o_hs_clk_on)
        else $error("idle_ls_only entry wrong");
    idle_both_a: assert property (halt_go && hs_on_in_halt && ls_on_in_halt
        |=> mode_reg == ocp_pkg::MODE_IDLE_BOTH_CLOCKS)
        else $error("idle_both_clocks entry wrong");
    idle_hs_a: assert property (halt_go && hs_on_in_halt && !ls_on_in_halt
        |=> mode_reg == ocp_pkg::MODE_IDLE_HS_ONLY)
        else $error("idle_hs_only entry wrong");
    cpu_hold_a: assert property (halt_go |=> ##1 o_cpu_hold)
        else $error("cpu not held after halt");
    xt_zero_a: assert property (rd_start && i_haddr == ocp_pkg::CRYSTAL_OSC_CTRL_ADDR
        |=> o_hrdata[7:3] == 5'h00)
        else $error("crystal unused bits read non-zero");

    // The divider must not move while the high-speed clock is unsettled.
    div_hold_a: assert property (!hs_stable_reg |=> $stable(o_sys_div_sel))
        else $error("divider changed while high-speed clock unstable");
    // A second halt while halted must leave the mode alone.
    halt_ignore_a: assert property (halted && i_halt_req && !i_wake |=> $stable(mode_reg))
        else $error("halt while halted changed the mode");
    // Waking always returns to the running modes through FAST.
    wake_fast_a: assert property (halted && i_wake |=> mode_reg == ocp_pkg::MODE_FAST)
        else $error("wake did not return to fast");
    // A crystal restart drops its stable flag at once.
    xt_restart_a: assert property (xt_restart |=> !xt_stable_reg)
        else $error("crystal stable flag did not clear on enable");
    // A cleared enable stops the high-speed RC on the next edge.
    hs_off_a: assert property (!hs_en_reg |=> !o_hs_osc_run)
        else $error("high-speed RC still running while disabled");
    // A cleared enable stops the crystal on the next edge.
    xt_off_a: assert property (!xt_en_reg |=> !o_crystal_run)
        else $error("crystal still running while disabled");
    // A time-out is never lost, even in a halt entry cycle.
    to_set_a: assert property (i_wdt_timeout |=> to_reg)
        else $error("time-out flag not set");
    // The clear instruction drops the power-down flag unless a halt wins.
    pdf_clear_a: assert property (i_clr_wdt && !halt_go |=> !pdf_reg)
        else $error("power-down flag not cleared");
    // The stable flag rises only when the count has reached its limit.
    hs_count_a: assert property ($rose(hs_stable_reg) |-> $past(hs_cnt_reg) == hs_lim)
        else $error("high-speed stable flag rose early");
    // Code 11 aliases to the lowest frequency.
    freq_code_a: assert property (hs_stable_reg && hs_freq_reg == 2'h3
        |=> o_hs_freq_mhz == ocp_pkg::FREQ_8_MHZ)
        else $error("frequency code 11 not decoded to 8 MHz");

    slow_switch_c: cover property ($rose(o_sys_ls_sel));
    sleep_entry_c: cover property (halt_go && !hs_on_in_halt && !ls_on_in_halt);
    wake_c: cover property (halted && i_wake);
    hs_stable_c: cover property ($rose(hs_stable_reg));
    // Both clocks kept alive through a halt.
    idle_both_c: cover property (mode_reg == ocp_pkg::MODE_IDLE_BOTH_CLOCKS);

endmodule // ocp_osc_control

`default_nettype wire

// ---- core/ocp_pkg.sv ----
`default_nettype none

package ocp_pkg;

    // ==========================================================
    // Register map (byte addresses).
    localparam logic [7:0] SYSCLK_CTRL_ADDR = 8'h00;
    localparam logic [7:0] HS_OSC_CTRL_ADDR = 8'h04;
    localparam logic [7:0] CRYSTAL_OSC_CTRL_ADDR = 8'h08;
    localparam logic [7:0] STATUS_ADDR = 8'h0c;

    // ==========================================================
    // Field positions.
    localparam int SYSCLK_SEL_LSB = 5;
    localparam int LOW_CLK_SRC_SEL_BIT = 2;
    localparam int HS_ON_IN_HALT_BIT = 1;
    localparam int LS_ON_IN_HALT_BIT = 0;
    localparam int HS_RC_FREQ_SEL_LSB = 2;
    localparam int STABLE_BIT = 1;
    localparam int OSC_EN_BIT = 0;
    localparam int CRYSTAL_SPEEDUP_BIT = 2;
    localparam int POWERDOWN_FLAG_BIT = 0;
    localparam int WDT_TIMEOUT_FLAG_BIT = 1;
    localparam int MODE_LSB = 4;

    // ==========================================================
    // Codes and reset values.
    localparam logic [2:0] SYSCLK_SEL_LOW = 3'h7;
    localparam logic [7:0] SYSCLK_CTRL_RESET = 8'h00;
    localparam logic [1:0] HS_RC_FREQ_RESET = 2'h0;
    localparam logic HS_OSC_EN_RESET = 1'b1;
    localparam logic [4:0] FREQ_8_MHZ = 5'h08;
    localparam logic [4:0] FREQ_12_MHZ = 5'h0c;
    localparam logic [4:0] FREQ_16_MHZ = 5'h10;

    // ==========================================================
    // Stabilisation counts in system clock cycles.
    localparam int HS_STABLE_CYCLES = 64;
    localparam int CRYSTAL_STABLE_SLOW_CYCLES = 256;
    localparam int CRYSTAL_STABLE_FAST_CYCLES = 32;
    localparam int STABLE_CNT_W = 12;

    // Operating modes.
    typedef enum logic [2:0] {
        MODE_FAST,
        MODE_SLOW,
        MODE_SLEEP,
        MODE_IDLE_LS_ONLY,
        MODE_IDLE_BOTH_CLOCKS,
        MODE_IDLE_HS_ONLY
    } ocp_mode_t;

endpackage

`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Clock, reset and design inputs.
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic halt = 1'b0;
    logic wake = 1'b0;
    logic clr_wdt = 1'b0;
    logic wdt_to = 1'b0;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic hs_run, xt_run, xt_sp, hs_on, ls_on, ls_sel, ls_xt, hold, wdt_clr;
    wire logic [4:0] freq;
    wire logic [2:0] div_sel;
    ocp_pkg::ocp_mode_t mode;
    int fails = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    int pulses;

    // Short stabilisation counts keep the run brief; expectations only wait past them.
    ocp_osc_control #(.HS_STABLE(4), .XT_STABLE_SLOW(8), .XT_STABLE_FAST(4)) uut (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .i_halt_req(halt), .i_wake(wake), .i_clr_wdt(clr_wdt), .i_wdt_timeout(wdt_to),
        .o_hs_osc_run(hs_run), .o_crystal_run(xt_run), .o_crystal_speedup(xt_sp),
        .o_hs_freq_mhz(freq), .o_hs_clk_on(hs_on), .o_ls_clk_on(ls_on),
        .o_sys_ls_sel(ls_sel), .o_sys_ls_crystal(ls_xt), .o_sys_div_sel(div_sel),
        .o_cpu_hold(hold), .o_wdt_clear(wdt_clr), .o_mode(mode));

    // ==========================================================
    // Clock generator.
    initial begin
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // Shared tasks.
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One single AHB transfer; the master holds each phase until hready is seen high.
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ahb(1'b1, a, {24'h0, d});
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rd, {24'h0, exp});
    endtask

    // One-cycle event pulse: 0 time-out, 1 halt, 2 wake, other clear-watchdog.
    task automatic pulse(input int which);
        @(posedge clk);
        case (which)
            0: wdt_to <= 1'b1;
            1: halt <= 1'b1;
            2: wake <= 1'b1;
            default: clr_wdt <= 1'b1;
        endcase
        @(posedge clk);
        wdt_to <= 1'b0;
        halt <= 1'b0;
        wake <= 1'b0;
        clr_wdt <= 1'b0;
    endtask

    // Verdict and end of run, shared by the main sequence and the watchdog.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog against a hung handshake.
    initial begin
        #(25 * 6000);
        fails++;
        wrap_up();
    end

    // ==========================================================
    // Main sequence.
    initial begin
        logic [4:0] fexp [4] = '{5'h0c, 5'h10, 5'h08, 5'h08};
        logic [1:0] hb [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        ocp_pkg::ocp_mode_t mexp [4] = '{ocp_pkg::MODE_SLEEP, ocp_pkg::MODE_IDLE_LS_ONLY,
            ocp_pkg::MODE_IDLE_BOTH_CLOCKS, ocp_pkg::MODE_IDLE_HS_ONLY};
        wait_clk(10);
        rst_n <= 1'b1;
        wait_clk(20);
        // Reset state and an unmapped place.
        rchk(8'h00, 8'h00);
        rchk(8'h04, 8'h03);
        rchk(8'h08, 8'h00);
        rchk(8'h0c, 8'h00);
        wr(8'h10, 8'hff);
        rchk(8'h10, 8'h00);
        chk(freq, 5'h08);
        chk({hreadyout, hresp}, 32'h2);
        // Frequency codes: new value only after the stable flag comes back.
        for (int i = 0; i < 4; i++) begin
            wr(8'h04, {4'h0, 2'((i + 1) % 4), 2'h1});
            chk(freq, (i == 0) ? 5'h08 : fexp[i - 1]);
            rchk(8'h04, {4'h0, 2'((i + 1) % 4), 2'h1});
            wait_clk(12);
            chk(freq, fexp[i]);
            rchk(8'h04, {4'h0, 2'((i + 1) % 4), 2'h3});
        end
        // Crystal control: unused bits, speed-up, enable and stable flag.
        wr(8'h08, 8'hff);
        rchk(8'h08, 8'h05);
        chk({xt_run, xt_sp}, 2'h3);
        wait_clk(12);
        rchk(8'h08, 8'h07);
        wr(8'h08, 8'h00);
        wait_clk(3);
        chk(xt_run, 1'b0);
        rchk(8'h08, 8'h00);
        // SLOW on the crystal waits until the crystal is stable.
        wr(8'h00, 8'he4);
        wait_clk(10);
        chk(ls_sel, 1'b0);
        wr(8'h08, 8'h01);
        wait_clk(2);
        chk(ls_sel, 1'b0);
        wait_clk(20);
        chk({ls_sel, ls_xt}, 2'h3);
        // Speed-up is locked while the crystal clocks the system.
        wr(8'h08, 8'h05);
        rchk(8'h08, 8'h03);
        chk(xt_sp, 1'b0);
        // SLOW on the low-speed RC, then FAST only after the high-speed RC restarts.
        wr(8'h00, 8'he0);
        wait_clk(4);
        chk({ls_sel, ls_xt, ls_on}, 3'h5);
        wr(8'h04, 8'h00);
        wait_clk(4);
        chk(hs_run, 1'b0);
        wr(8'h00, 8'h00);
        wait_clk(10);
        chk(ls_sel, 1'b1);
        wr(8'h04, 8'h01);
        wait_clk(20);
        chk({ls_sel, hs_on}, 2'h1);
        // Every divider code.
        for (int c = 0; c < 7; c++) begin
            wr(8'h00, {3'(c), 5'h00});
            wait_clk(4);
            chk({ls_sel, div_sel}, {1'b0, 3'(c)});
        end
        // Every halt mode, with a time-out flag standing before entry.
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, {6'h00, hb[i]});
            pulse(0);
            wait_clk(2);
            rchk(8'h0c, 8'h02);
            pulses = 0;
            @(posedge clk);
            halt <= 1'b1;
            @(posedge clk);
            halt <= 1'b0;
            repeat (4) begin
                @(posedge clk);
                pulses += (wdt_clr === 1'b1) ? 1 : 0;
            end
            chk(pulses, 1);
            chk({hold, hs_on, ls_on}, {1'b1, hb[i][1], hb[i][0]});
            chk(mode, mexp[i]);
            rchk(8'h0c, {1'b0, 3'(mexp[i]), 4'h1});
            rchk(8'h00, {6'h00, hb[i]});
            pulse(1);
            wait_clk(3);
            chk(mode, mexp[i]);
            pulse(2);
            wait_clk(4);
            chk({hold, 1'b0, mode}, {1'b0, 1'b0, ocp_pkg::MODE_FAST});
            pulse(3);
            wait_clk(2);
            rchk(8'h0c, 8'h00);
        end
        wrap_up();
    end
endmodule // tb

`default_nettype wire
